// ---- tb/sbm_matrix_assertions.sv ----
// concurrent checks on the bus matrix ports
`timescale 1ns/1ps
module sbm_matrix_assertions
    import sbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire sbm_pkg::sbm_mrsp_t [sbm_pkg::NUM_MST-1:0] m_rsp,
    input wire logic [sbm_pkg::NUM_SLV-1:0] s_sel,
    input wire logic [1:0] s_trans,
    input wire logic s_enable,
    input wire logic [1:0] s_bridge,
    input wire logic [31:0] s_addr,
    input wire logic [2:0] s_size,
    input wire logic [3:0] s_strb
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire ap = s_trans == 2'h2;
    wire e0 = m_rsp[0].resp && !m_rsp[0].ready;
    a_one_master: assert property (!(m_rsp[0].ready && m_rsp[1].ready))
        else $error("both masters answered");
    a_ready_pulse: assert property (m_rsp[1].ready |=> !m_rsp[1].ready)
        else $error("ready longer than one cycle");
    a_answer_bound: assert property ($rose(|s_sel) |-> ##[2:12] (m_rsp[0].ready || m_rsp[1].ready))
        else $error("no answer after select");
    a_flash_win: assert property (ap && s_addr[31:16] == 16'h0 |-> s_sel[0])
        else $error("flash not selected");
    a_sram_win: assert property (ap && s_addr[31:13] == 19'h1_0000 |-> s_sel[3])
        else $error("sram not selected");
    a_port_f_win: assert property (ap && s_addr[31:10] == 22'h12_0005 |-> s_sel[26])
        else $error("port f not selected");
    a_unmapped_err: assert property (e0 |-> s_sel == 27'h0 ##1 (m_rsp[0].ready && m_rsp[0].resp))
        else $error("bad error response");
    a_byte_lane: assert property (ap && s_size == 3'h0 |-> s_strb == 4'h1 << s_addr[1:0])
        else $error("byte lane wrong");
    a_word_lane: assert property (ap && s_size == 3'h2 |-> s_strb == 4'hf)
        else $error("word lanes wrong");
    a_apb_access: assert property (s_enable |-> (s_sel & SLV_IS_APB) != 27'h0 && $stable(s_sel))
        else $error("apb access phase wrong");
    a_uart_bridge: assert property (s_enable && s_sel[17] |-> s_bridge == 2'h2)
        else $error("wrong bridge");
    a_trans_kind: assert property ($rose(|s_sel) |-> ((s_trans == 2'h2) == ((s_sel & SLV_IS_APB) == 27'h0)))
        else $error("address phase kind wrong");
    c_dma_done: cover property (m_rsp[1].ready);
    c_apb_access: cover property (s_enable);
    c_error: cover property (m_rsp[0].resp && m_rsp[0].ready);
endmodule

bind sbm_matrix sbm_matrix_assertions sbm_matrix_assertions_i (.clk(clk), .rst_b(rst_b),
    .m_rsp(m_rsp), .s_sel(s_sel), .s_trans(s_trans), .s_enable(s_enable), .s_bridge(s_bridge),
    .s_addr(s_addr), .s_size(s_size), .s_strb(s_strb));

// ---- tb/sbm_slave_model.sv ----
// slave side responder: ready now or every other cycle, per-slave read pattern
`timescale 1ns/1ps
module sbm_slave_model
    import sbm_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    output logic [sbm_pkg::NUM_SLV-1:0] s_ready,
    output logic [31:0] s_rdata [sbm_pkg::NUM_SLV]
);
    logic tog = 1'b0;
    always @(posedge clk)
        tog <= ~tog;
    // slow mode adds wait states so the matrix must hold its phases
    assign s_ready = {NUM_SLV{tog | ~slow}};
    always_comb
        for (int i = 0; i < NUM_SLV; i++)
            s_rdata[i] = 32'h1122_3300 | 32'(i);
endmodule

// ---- tb/test_sbm_matrix.sv ----
// self-checking bench for the system bus matrix
`timescale 1ns/1ps
module test_sbm_matrix;
    import sbm_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic slow = 1'b0;
    sbm_mreq_t [NUM_MST-1:0] m_req = '0;
    sbm_mrsp_t [NUM_MST-1:0] m_rsp;
    logic [NUM_SLV-1:0] s_sel, s_ready;
    logic [NUM_SLV-1:0] s_err = '0;
    logic [1:0] s_trans, s_bridge;
    logic s_enable, s_write;
    logic [31:0] s_addr, s_wdata;
    logic [31:0] s_rdata [NUM_SLV];
    logic [2:0] s_size;
    logic [3:0] s_strb;
    int fails = 0;
    int tests_run = 0;
    int seq = 0;
    int ord [2];
    logic [NUM_SLV-1:0] sel_seen [2];
    logic [31:0] rd_seen [2];
    logic err_seen [2];

    sbm_matrix sbm_matrix_i (.clk(clk), .rst_b(rst_b), .m_req(m_req), .m_rsp(m_rsp),
        .s_sel(s_sel), .s_trans(s_trans), .s_enable(s_enable), .s_bridge(s_bridge),
        .s_addr(s_addr), .s_write(s_write), .s_size(s_size), .s_wdata(s_wdata),
        .s_strb(s_strb), .s_ready(s_ready), .s_err(s_err), .s_rdata(s_rdata));
    sbm_slave_model sbm_slave_model_i (.clk(clk), .slow(slow), .s_ready(s_ready),
        .s_rdata(s_rdata));

    initial
        forever #20 clk = ~clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input int m, input logic [31:0] a, input logic [2:0] sz, input logic w);
        int n;
        @(negedge clk);
        m_req[m].addr = a;
        m_req[m].size = sz;
        m_req[m].write = w;
        m_req[m].wdata = 32'h1122_3344;
        m_req[m].trans = HTRANS_NONSEQ;
        sel_seen[m] = '0;
        n = 0;
        // request held until the edge where ready is sampled
        while (m_rsp[m].ready !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            sel_seen[m] |= s_sel;
            n++;
        end
        check("answer", 32'h1, 32'(n < 40));
        err_seen[m] = m_rsp[m].resp;
        rd_seen[m] = m_rsp[m].rdata;
        ord[m] = seq++;
        @(negedge clk);
        m_req[m].trans = HTRANS_IDLE;
    endtask

    task automatic t_decode();
        logic [31:0] ua [4] = '{32'h0001_0000, 32'h2000_2000, 32'h4000_0000, 32'he000_0000};
        logic [31:0] ka [4] = '{32'h4800_0800, 32'h4001_4c00, 32'h4000_5400, 32'h0010_0bff};
        int ki [4] = '{25, 19, 11, 2};
        for (int i = 0; i < NUM_SLV; i++)
        begin
            slow = i[0];
            xfer(0, SLV_BASE[i], 3'h2, 1'b0);
            check("sel base", 32'h1 << i, 32'(sel_seen[0]));
            xfer(1, SLV_LAST[i], 3'h2, 1'b0);
            check("sel last", 32'h1 << i, 32'(sel_seen[1]));
            check("addr last", SLV_LAST[i], s_addr);
            check("read dir", 32'h0, 32'(s_write));
            check("rdata", 32'h1122_3300 | 32'(i), rd_seen[1]);
        end
        for (int i = 0; i < 4; i++)
        begin
            xfer(0, ka[i], 3'h2, 1'b0);
            check("sel known", 32'h1 << ki[i], 32'(sel_seen[0]));
            xfer(0, ua[i], 3'h2, 1'b0);
            check("unmapped err", 32'h1, 32'(err_seen[0]));
            check("unmapped sel", 32'h0, 32'(sel_seen[0]));
        end
        s_err[21] = 1'b1;
        xfer(1, 32'h4002_2000, 3'h2, 1'b0);
        check("slave err", 32'h1, 32'(err_seen[1]));
        s_err[21] = 1'b0;
    endtask

    task automatic t_lanes();
        for (int k = 0; k < 4; k++)
        begin
            xfer(1, 32'h2000_0000 + k, HSIZE_BYTE, 1'b1);
            check("byte strb", 32'h1 << k, 32'(s_strb));
        end
        xfer(0, 32'h2000_0002, HSIZE_HALF, 1'b1);
        check("half strb", 32'hc, 32'(s_strb));
        check("half size", 32'(HSIZE_HALF), 32'(s_size));
        check("write dir", 32'h1, 32'(s_write));
        xfer(0, 32'h2000_0000, 3'h2, 1'b1);
        check("word strb", 32'hf, 32'(s_strb));
        check("wdata", 32'h1122_3344, s_wdata);
    endtask

    task automatic t_arb();
        for (int r = 0; r < 2; r++)
        begin
            xfer(r, 32'h2000_0000, 3'h2, 1'b0);
            fork
                xfer(0, 32'h0000_0100, 3'h2, 1'b0);
                xfer(1, 32'h4001_3800, 3'h2, 1'b0);
            join
            check("tie winner", 32'(r == 0), 32'(ord[1] < ord[0]));
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        fails++;
        end_sim();
    end

    initial
    begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        t_decode();
        t_lanes();
        t_arb();
        end_sim();
    end
endmodule

// ---- verilog/sbm_addr_decoder.sv ----
// address decoder: full 32-bit window compare against the slave map
`timescale 1ns/1ps
module sbm_addr_decoder
    import sbm_pkg::*;
(
    input wire logic [31:0] addr,
    output logic [sbm_pkg::NUM_SLV-1:0] hit,
    output logic [sbm_pkg::SLV_W-1:0] slv_idx,
    output logic miss
);
    import sbm_pkg::*;

    genvar g;
    generate
        for (g = 0; g < NUM_SLV; g++)
        begin : g_win
            // all 32 address bits take part, so aliases never decode
            assign hit[g] = (addr >= SLV_BASE[g]) && (addr <= SLV_LAST[g]);
        end
    endgenerate

    assign miss = ~|hit;

    always_comb
    begin
        slv_idx = RST_SLV;
        for (int i = 0; i < NUM_SLV; i++)
        begin
            if (hit[i])
            begin
                slv_idx = SLV_W'(i);
            end
        end
    end
endmodule

// ---- verilog/sbm_matrix.sv ----
// system bus matrix: two masters, round-robin arbiter, ahb and apb slave sides
// Overview of operation
// - two masters, core and dma, reach every slave
// - contention alternates grant between core and dma
// - byte lanes are little-endian
// - one linear 32-bit address space decoded
// - apb bridges run on the matrix clock
// - dma, flash controller, crc windows decoded
// - ports a, b, c, f windows decoded
// - basic timers and wakeup timer decoded
// - advanced timer, spi, uart one decoded
// - system control, adc, i2c decoded
// - general timers and rtc decoded
// - watchdogs and uart two decoded
// - uart three, comparator block decoded
// - flash region decoded from address zero
// - sram region decoded
// - otp region decoded
`timescale 1ns/1ps
module sbm_matrix
    import sbm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire sbm_pkg::sbm_mreq_t [sbm_pkg::NUM_MST-1:0] m_req,
    output sbm_pkg::sbm_mrsp_t [sbm_pkg::NUM_MST-1:0] m_rsp,
    output logic [sbm_pkg::NUM_SLV-1:0] s_sel,
    output logic [1:0] s_trans,
    output logic s_enable,
    output logic [1:0] s_bridge,
    output logic [31:0] s_addr,
    output logic s_write,
    output logic [2:0] s_size,
    output logic [31:0] s_wdata,
    output logic [3:0] s_strb,
    input wire logic [sbm_pkg::NUM_SLV-1:0] s_ready,
    input wire logic [sbm_pkg::NUM_SLV-1:0] s_err,
    input wire logic [31:0] s_rdata [sbm_pkg::NUM_SLV]
);
    import sbm_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_AHB_ADDR,
        ST_AHB_DATA,
        ST_APB_SETUP,
        ST_APB_ACCESS,
        ST_ERR,
        ST_DONE
    } sbm_state_t;

    sbm_state_t state_reg;
    sbm_state_t state_next;

    logic owner_reg;
    logic last_grant_reg;
    logic [SLV_W-1:0] sel_reg;
    logic [1:0] bridge_reg;
    logic [31:0] addr_reg;
    logic write_reg;
    logic [2:0] size_reg;
    logic [31:0] wdata_reg;
    logic [3:0] strb_reg;
    logic [31:0] rdata_reg;
    logic err_reg;

    // arbitration
    wire req_core = m_req[MST_CORE].trans[1];
    wire req_dma = m_req[MST_DMA].trans[1];
    wire any_req = req_core | req_dma;
    wire both_req = req_core & req_dma;
    // the master not served last wins a tie, so neither can starve the other
    wire pick = both_req ? ~last_grant_reg : req_dma;
    wire start = (state_reg == ST_IDLE) && any_req;

    wire sbm_mreq_t pick_req = m_req[pick];

    logic [NUM_SLV-1:0] dec_hit;
    logic [SLV_W-1:0] dec_idx;
    logic dec_miss;

    sbm_addr_decoder u_dec (
        .addr(pick_req.addr),
        .hit(dec_hit),
        .slv_idx(dec_idx),
        .miss(dec_miss)
    );

    wire dec_apb = SLV_IS_APB[dec_idx];

    // little-endian lane map: byte k of a word lives at address base + k
    function automatic logic [3:0] lane_strb(input logic [1:0] a, input logic [2:0] sz);
        logic [3:0] s;
        s = 4'hf;
        if (sz == HSIZE_BYTE)
        begin
            s = 4'(4'h1 << a);
        end
        else if (sz == HSIZE_HALF)
        begin
            s = a[1] ? 4'hc : 4'h3;
        end
        return s;
    endfunction

    wire [3:0] pick_strb = lane_strb(pick_req.addr[1:0], pick_req.size);

    wire slv_ready = s_ready[sel_reg];
    wire slv_err = s_err[sel_reg];
    wire [31:0] slv_rdata = s_rdata[sel_reg];

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (any_req)
                begin
                    if (dec_miss)
                    begin
                        state_next = ST_ERR;
                    end
                    else if (dec_apb)
                    begin
                        state_next = ST_APB_SETUP;
                    end
                    else
                    begin
                        state_next = ST_AHB_ADDR;
                    end
                end
            end
            ST_AHB_ADDR:
            begin
                state_next = ST_AHB_DATA;
            end
            ST_AHB_DATA:
            begin
                if (slv_ready)
                begin
                    state_next = ST_DONE;
                end
            end
            ST_APB_SETUP:
            begin
                state_next = ST_APB_ACCESS;
            end
            ST_APB_ACCESS:
            begin
                if (slv_ready)
                begin
                    state_next = ST_DONE;
                end
            end
            ST_ERR:
            begin
                state_next = ST_DONE;
            end
            ST_DONE:
            begin
                // one idle cycle follows, so a waiting master is seen before a repeat
                state_next = ST_IDLE;
            end
            default:
            begin
                // the eighth code is unused; an upset falls back to idle
                state_next = ST_IDLE;
            end
        endcase
    end

    wire data_done = ((state_reg == ST_AHB_DATA) || (state_reg == ST_APB_ACCESS)) && slv_ready;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // arbitration memory: owner of the path and winner of the last take
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            owner_reg <= 1'b0;
            last_grant_reg <= RST_LAST_GRANT;
        end
        else if (start)
        begin
            owner_reg <= pick;
            last_grant_reg <= pick;
        end
    end

    // slave choice is frozen at the take edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_reg <= RST_SLV;
            bridge_reg <= 2'h0;
        end
        else if (start)
        begin
            sel_reg <= dec_idx;
            bridge_reg <= SLV_BRIDGE[dec_idx];
        end
    end

    // request copy; masters keep the request up until ready, so one copy suffices
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_reg <= RST_WORD;
            write_reg <= 1'b0;
            size_reg <= 3'h0;
            wdata_reg <= RST_WORD;
            strb_reg <= 4'h0;
        end
        else if (start)
        begin
            addr_reg <= pick_req.addr;
            write_reg <= pick_req.write;
            size_reg <= pick_req.size;
            wdata_reg <= pick_req.wdata;
            strb_reg <= pick_strb;
        end
    end

    // read data stands until the next slave data phase ends, a miss leaves it; writes leave zero behind
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_reg <= RST_WORD;
        end
        else if (data_done)
        begin
            rdata_reg <= write_reg ? RST_WORD : slv_rdata;
        end
    end

    // error flag: cleared on take, set by a miss or by the slave's answer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            err_reg <= 1'b0;
        end
        else if (start)
        begin
            err_reg <= 1'b0;
        end
        else if (state_reg == ST_ERR)
        begin
            err_reg <= 1'b1;
        end
        else if (data_done)
        begin
            err_reg <= slv_err;
        end
    end

    // slave side
    wire sel_phase = (state_reg == ST_AHB_ADDR) || (state_reg == ST_APB_SETUP)
                     || (state_reg == ST_APB_ACCESS);
    // one compare per slave rather than a wide shift
    genvar s;
    generate
        for (s = 0; s < NUM_SLV; s++)
        begin : g_sel
            assign s_sel[s] = sel_phase && (sel_reg == SLV_W'(s));
        end
    endgenerate

    assign s_trans = (state_reg == ST_AHB_ADDR) ? HTRANS_NONSEQ : HTRANS_IDLE;
    assign s_enable = (state_reg == ST_APB_ACCESS);
    assign s_bridge = bridge_reg;
    assign s_addr = addr_reg;
    assign s_write = write_reg;
    assign s_size = size_reg;
    assign s_wdata = wdata_reg;
    assign s_strb = strb_reg;

    // master side: ready pulses once per finished transfer, error is two cycles long for a miss, one cycle for a slave error
    genvar m;
    generate
        for (m = 0; m < NUM_MST; m++)
        begin : g_rsp
            wire owns = (owner_reg == 1'(m));
            assign m_rsp[m].ready = owns && (state_reg == ST_DONE);
            assign m_rsp[m].resp = owns && ((state_reg == ST_ERR)
                                   || ((state_reg == ST_DONE) && err_reg));
            assign m_rsp[m].rdata = rdata_reg;
        end
    endgenerate
endmodule

// ---- verilog/sbm_pkg.sv ----
// shared constants, address map and carrier types of the system bus matrix
package sbm_pkg;

    localparam int NUM_MST = 2;
    localparam int NUM_SLV = 27;
    localparam int SLV_W = 5;
    localparam int MST_CORE = 0;
    localparam int MST_DMA = 1;

    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [SLV_W-1:0] RST_SLV = 5'h00;
    localparam logic RST_LAST_GRANT = 1'b1;

    // slave order: flash, boot, otp, sram, apb1 x6, apb2 x5, apb3 x3, apb4 x2, ahb regs, ports
    localparam logic [31:0] SLV_BASE [NUM_SLV] = '{
        32'h0000_0000,
        32'h0010_0000,
        32'h0010_0b80,
        32'h2000_0000,
        32'h4000_0400, 32'h4000_1000, 32'h4000_2800,
        32'h4000_2c00, 32'h4000_3000, 32'h4000_4400,
        32'h4000_4800,
        32'h4000_5400, 32'h4001_0000, 32'h4001_2400,
        32'h4001_2800,
        32'h4001_2c00, 32'h4001_3000, 32'h4001_3800,
        32'h4001_4800, 32'h4001_4c00,
        32'h4002_0000, 32'h4002_2000, 32'h4002_3000,
        32'h4800_0000, 32'h4800_0400, 32'h4800_0800, 32'h4800_1400
    };
    localparam logic [31:0] SLV_LAST [NUM_SLV] = '{
        32'h0000_ffff, 32'h0010_09ff, 32'h0010_0bff, 32'h2000_1fff,
        32'h4000_07ff, 32'h4000_13ff, 32'h4000_2bff,
        32'h4000_2fff, 32'h4000_33ff, 32'h4000_47ff,
        32'h4000_4bff, 32'h4000_57ff, 32'h4001_03ff, 32'h4001_27ff, 32'h4001_2bff,
        32'h4001_2fff, 32'h4001_33ff, 32'h4001_3bff,
        32'h4001_4bff, 32'h4001_4fff,
        32'h4002_03ff, 32'h4002_23ff, 32'h4002_33ff,
        32'h4800_03ff, 32'h4800_07ff, 32'h4800_0bff, 32'h4800_17ff
    };
    // bit i set: slave i sits behind an apb bridge
    localparam logic [NUM_SLV-1:0] SLV_IS_APB = 27'h00f_fff0;
    localparam logic [1:0] SLV_BRIDGE [NUM_SLV] = '{
        2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
        2'h2, 2'h2, 2'h2,
        2'h3, 2'h3,
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0
    };

    typedef struct packed {
        logic [31:0] addr;
        logic [1:0] trans;
        logic write;
        logic [2:0] size;
        logic [31:0] wdata;
    } sbm_mreq_t;

    typedef struct packed {
        logic ready;
        logic resp;
        logic [31:0] rdata;
    } sbm_mrsp_t;

endpackage
